// [ieg_params.svh]
`ifndef IEG_PARAMS_SVH
`define IEG_PARAMS_SVH

// Byte offsets of the registers inside the slave's 4 KB window.
`define IEG_OFS_CAN_EN      12'h000
`define IEG_OFS_GROUP3      12'h004
`define IEG_OFS_STATUS      12'h008

// Low address bits that take part in the register decode.
`define IEG_DEC_MSB         11

// Field positions in the CAN enable register.
`define IEG_BIT_CAN_EVENT   3
`define IEG_BIT_CAN_RX      2

// Field positions in the third enable register.
`define IEG_BIT_CALENDAR    14
`define IEG_BIT_DMA5        13

// Writable bits of each enable register; every other bit reads zero.
`define IEG_MASK_CAN_EN     16'h000c
`define IEG_MASK_GROUP3     16'h6000

// Power-on values of the enable registers.
`define IEG_RST_CAN_EN      16'h0000
`define IEG_RST_GROUP3      16'h0000

// Status register layout: pending flags low, forwarded requests above.
`define IEG_STAT_FLAG_LSB   0
`define IEG_STAT_REQ_LSB    4

// Number of interrupt sources handled by this block.
`define IEG_NUM_SRC         4

`endif

// [ieg_pkg.sv]
package ieg_pkg;

	// Transfer types of the register bus.
	typedef enum logic [1:0] {
		IEG_TR_IDLE   = 2'b00,
		IEG_TR_BUSY   = 2'b01,
		IEG_TR_NONSEQ = 2'b10,
		IEG_TR_SEQ    = 2'b11
	} ieg_trans_t;

	// One sixteen-bit enable register.
	typedef logic [15:0] ieg_reg_t;

	// Source index order used for flags and requests.
	typedef enum logic [1:0] {
		IEG_SRC_CAN_EVENT = 2'b00,
		IEG_SRC_CAN_RX    = 2'b01,
		IEG_SRC_CALENDAR  = 2'b10,
		IEG_SRC_DMA5      = 2'b11
	} ieg_src_t;

endpackage

// [ieg_interrupt_enable_group_bits.sv]
`timescale 1ns/100ps
`include "ieg_params.svh"

module ieg_interrupt_enable_group_bits #(
	parameter bit CAN_PRESENT = 1'b1
) (
	input  wire logic                 i_clk,
	input  wire logic                 i_nrst,
	input  wire logic                 i_hsel,
	input  wire logic [31:0]          i_haddr,
	input  wire ieg_pkg::ieg_trans_t  i_htrans,
	input  wire logic                 i_hwrite,
	input  wire logic [2:0]           i_hsize,
	input  wire logic [31:0]          i_hwdata,
	input  wire logic                 i_hready,
	output logic      [31:0]          o_hrdata,
	output logic                      o_hreadyout,
	output logic                      o_hresp,
	input  wire logic                 i_can_event_flag,
	input  wire logic                 i_can_rx_flag,
	input  wire logic                 i_calendar_flag,
	input  wire logic                 i_dma5_flag,
	output logic                      o_can_event_req,
	output logic                      o_can_rx_req,
	output logic                      o_calendar_req,
	output logic                      o_dma5_req
);
	import ieg_pkg::*;

	// Bus state carried from the address phase into the data phase.
	logic [`IEG_DEC_MSB:0]  addr_ff;
	logic [`IEG_DEC_MSB:0]  nxt_addr;
	logic                   wr_ff;
	logic                   nxt_wr;
	logic [31:0]            hrdata_ff;
	logic [31:0]            nxt_hrdata;

	// Enable registers.
	ieg_reg_t               can_en_ff;
	ieg_reg_t               nxt_can_en;
	ieg_reg_t               group3_ff;
	ieg_reg_t               nxt_group3;

	// Forwarded requests, one per source.
	logic [`IEG_NUM_SRC-1:0] req_ff;
	logic [`IEG_NUM_SRC-1:0] nxt_req;
	logic [`IEG_NUM_SRC-1:0] flags;
	logic [`IEG_NUM_SRC-1:0] enables;

	logic                   addr_phase;

	// Compares the decoded address bits against one register offset.
	function automatic logic reg_hit(
		input logic [`IEG_DEC_MSB:0] addr,
		input logic [`IEG_DEC_MSB:0] ofs
	);
		reg_hit = (addr[`IEG_DEC_MSB:2] == ofs[`IEG_DEC_MSB:2]);
	endfunction

	// Builds the read word for an offset; unmapped offsets read zero.
	function automatic logic [31:0] read_word(
		input logic [`IEG_DEC_MSB:0] addr,
		input ieg_reg_t              can_en,
		input ieg_reg_t              group3,
		input logic [`IEG_NUM_SRC-1:0] flg,
		input logic [`IEG_NUM_SRC-1:0] req
	);
		logic [31:0] stat;
		stat = 32'h0000_0000;
		stat[`IEG_STAT_FLAG_LSB +: `IEG_NUM_SRC] = flg;
		stat[`IEG_STAT_REQ_LSB +: `IEG_NUM_SRC] = req;
		if (reg_hit(addr, `IEG_OFS_CAN_EN)) begin
			read_word = {16'h0000, can_en & `IEG_MASK_CAN_EN};
		end else if (reg_hit(addr, `IEG_OFS_GROUP3)) begin
			read_word = {16'h0000, group3 & `IEG_MASK_GROUP3};
		end else if (reg_hit(addr, `IEG_OFS_STATUS)) begin
			read_word = stat;
		end else begin
			read_word = 32'h0000_0000;
		end
	endfunction

	// The slave never stretches a transfer and always answers OKAY, so
	// a transfer completes one cycle after its address phase.
	assign o_hreadyout = 1'b1;
	assign o_hresp     = 1'b0;
	assign o_hrdata    = hrdata_ff;

	// A transfer starts when selected, active and the bus is ready.
	assign addr_phase = i_hsel && i_hready &&
		(i_htrans == IEG_TR_NONSEQ || i_htrans == IEG_TR_SEQ);

	// Pending flags belong to the sources; this block only reads them.
	assign flags[IEG_SRC_CAN_EVENT] = i_can_event_flag;
	assign flags[IEG_SRC_CAN_RX]    = i_can_rx_flag;
	assign flags[IEG_SRC_CALENDAR]  = i_calendar_flag;
	assign flags[IEG_SRC_DMA5]      = i_dma5_flag;

	// Effective enables; the CAN ones are dead on parts without CAN.
	assign enables[IEG_SRC_CAN_EVENT] =
		can_en_ff[`IEG_BIT_CAN_EVENT] && CAN_PRESENT;
	assign enables[IEG_SRC_CAN_RX] =
		can_en_ff[`IEG_BIT_CAN_RX] && CAN_PRESENT;
	assign enables[IEG_SRC_CALENDAR] =
		group3_ff[`IEG_BIT_CALENDAR];
	assign enables[IEG_SRC_DMA5] =
		group3_ff[`IEG_BIT_DMA5];

	// Next bus-phase state and register contents.
	always_comb begin
		nxt_addr   = addr_ff;
		nxt_wr     = 1'b0;
		nxt_can_en = can_en_ff;
		nxt_group3 = group3_ff;
		nxt_hrdata = hrdata_ff;
		// Data phase of a write: hwdata is valid now.
		if (wr_ff) begin
			if (reg_hit(addr_ff, `IEG_OFS_CAN_EN)) begin
				nxt_can_en = i_hwdata[15:0] & `IEG_MASK_CAN_EN;
			end
			if (reg_hit(addr_ff, `IEG_OFS_GROUP3)) begin
				// Only bits 14 and 13 store; the rest stay zero.
				nxt_group3 = i_hwdata[15:0] & `IEG_MASK_GROUP3;
			end
		end
		// Address phase: latch write intent, or prepare read data.
		if (addr_phase) begin
			nxt_addr = i_haddr[`IEG_DEC_MSB:0];
			nxt_wr   = i_hwrite;
			if (!i_hwrite) begin
				// Reading from the next values forwards a write that
				// completes in this same cycle to a back-to-back read.
				nxt_hrdata = read_word(i_haddr[`IEG_DEC_MSB:0],
					nxt_can_en, nxt_group3, flags, req_ff);
			end
		end
	end

	// Bus-phase state and enable registers.
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			addr_ff   <= '0;
			wr_ff     <= 1'b0;
			hrdata_ff <= 32'h0000_0000;
			can_en_ff <= `IEG_RST_CAN_EN;
			group3_ff <= `IEG_RST_GROUP3;
		end else begin
			addr_ff   <= nxt_addr;
			wr_ff     <= nxt_wr;
			hrdata_ff <= nxt_hrdata;
			can_en_ff <= nxt_can_en;
			group3_ff <= nxt_group3;
		end
	end

	// Each request is its flag passed through its enable, nothing more.
	always_comb begin
		nxt_req = flags & enables;
	end

	// Requests are registered so the core sees glitch-free levels.
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			req_ff <= '0;
		end else begin
			req_ff <= nxt_req;
		end
	end

	assign o_can_event_req = req_ff[IEG_SRC_CAN_EVENT];
	assign o_can_rx_req    = req_ff[IEG_SRC_CAN_RX];
	assign o_calendar_req  = req_ff[IEG_SRC_CALENDAR];
	assign o_dma5_req      = req_ff[IEG_SRC_DMA5];

	// A CAN event request follows flag and enable one cycle later.
	chk_can_event_gate: assert property (
		@(posedge i_clk) disable iff (!i_nrst)
		##1 o_can_event_req == $past(i_can_event_flag &&
			can_en_ff[`IEG_BIT_CAN_EVENT] && CAN_PRESENT))
		else $error("CAN event request does not match its gate");

	// A write of bit 2 makes the receive-ready source pass two cycles on.
	chk_can_rx_enable: assert property (
		@(posedge i_clk) disable iff (!i_nrst)
		(wr_ff && reg_hit(addr_ff, `IEG_OFS_CAN_EN)) ##1
		(i_can_rx_flag && CAN_PRESENT)
		|=> o_can_rx_req == $past(i_hwdata[`IEG_BIT_CAN_RX], 2))
		else $error("CAN receive request ignores the written enable");

	// The calendar request never rises while its enable is clear.
	chk_calendar_gate: assert property (
		@(posedge i_clk) disable iff (!i_nrst)
		!group3_ff[`IEG_BIT_CALENDAR] |=> !o_calendar_req)
		else $error("Calendar request raised while disabled");

	// A write to group 3 lands in the register and gates DMA 5.
	chk_dma5_write: assert property (
		@(posedge i_clk) disable iff (!i_nrst)
		(wr_ff && reg_hit(addr_ff, `IEG_OFS_GROUP3))
		|=> group3_ff[`IEG_BIT_DMA5] == $past(i_hwdata[`IEG_BIT_DMA5])
		##1 o_dma5_req == ($past(i_dma5_flag) &&
			$past(group3_ff[`IEG_BIT_DMA5])))
		else $error("DMA 5 enable write not applied");

	// Unimplemented group 3 bits hold and read as zero.
	chk_group3_zero: assert property (
		@(posedge i_clk) disable iff (!i_nrst)
		(addr_phase && !i_hwrite &&
			reg_hit(i_haddr[`IEG_DEC_MSB:0], `IEG_OFS_GROUP3))
		|=> (o_hrdata & ~{16'h0000, `IEG_MASK_GROUP3}) == 32'h0000_0000
			&& (group3_ff & ~`IEG_MASK_GROUP3) == 16'h0000)
		else $error("Unimplemented group 3 bit reads as one");

	// On parts without CAN both CAN requests stay low throughout.
	chk_no_can_part: assert property (
		@(posedge i_clk) disable iff (!i_nrst)
		!CAN_PRESENT |-> !o_can_event_req && !o_can_rx_req)
		else $error("CAN request raised on a part without CAN");

	// Turning an enable on with no flag pending raises no request.
	chk_flag_untouched: assert property (
		@(posedge i_clk) disable iff (!i_nrst)
		($rose(group3_ff[`IEG_BIT_CALENDAR]) && !i_calendar_flag)
		|=> !o_calendar_req)
		else $error("Enable change created a request without a flag");

	// Read data of the status register mirrors the pending flags.
	chk_status_read: assert property (
		@(posedge i_clk) disable iff (!i_nrst)
		(addr_phase && !i_hwrite &&
			reg_hit(i_haddr[`IEG_DEC_MSB:0], `IEG_OFS_STATUS))
		|=> o_hrdata[`IEG_STAT_FLAG_LSB +: `IEG_NUM_SRC] == $past(flags))
		else $error("Status read does not show the pending flags");

	// A write to the CAN register lands the event enable bit.
	chk_can_event_write: assert property (
		@(posedge i_clk) disable iff (!i_nrst)
		(wr_ff && reg_hit(addr_ff, `IEG_OFS_CAN_EN))
		|=> can_en_ff[`IEG_BIT_CAN_EVENT] ==
			$past(i_hwdata[`IEG_BIT_CAN_EVENT]))
		else $error("CAN event enable write not applied");

	// A CAN register read returns the stored enables, upper half zero.
	chk_can_en_read: assert property (
		@(posedge i_clk) disable iff (!i_nrst)
		(addr_phase && !i_hwrite &&
			reg_hit(i_haddr[`IEG_DEC_MSB:0], `IEG_OFS_CAN_EN))
		|=> o_hrdata == {16'h0000, can_en_ff})
		else $error("CAN enable register read back wrong");

	// A write to group 3 lands the calendar enable bit.
	chk_calendar_write: assert property (
		@(posedge i_clk) disable iff (!i_nrst)
		(wr_ff && reg_hit(addr_ff, `IEG_OFS_GROUP3))
		|=> group3_ff[`IEG_BIT_CALENDAR] ==
			$past(i_hwdata[`IEG_BIT_CALENDAR]))
		else $error("Calendar enable write not applied");

	// A group 3 read returns the stored enables in the low half.
	chk_group3_read: assert property (
		@(posedge i_clk) disable iff (!i_nrst)
		(addr_phase && !i_hwrite &&
			reg_hit(i_haddr[`IEG_DEC_MSB:0], `IEG_OFS_GROUP3))
		|=> o_hrdata == {16'h0000, group3_ff})
		else $error("Group 3 register read back wrong");

	// The DMA 5 request never rises while its enable is clear.
	chk_dma5_gate: assert property (
		@(posedge i_clk) disable iff (!i_nrst)
		!group3_ff[`IEG_BIT_DMA5] |=> !o_dma5_req)
		else $error("DMA 5 request raised while disabled");

	// Writes to the status or unmapped offsets leave the enables alone.
	chk_unmapped_write: assert property (
		@(posedge i_clk) disable iff (!i_nrst)
		(wr_ff && !reg_hit(addr_ff, `IEG_OFS_CAN_EN) &&
			!reg_hit(addr_ff, `IEG_OFS_GROUP3))
		|=> $stable(can_en_ff) && $stable(group3_ff))
		else $error("Write to an unmapped offset changed an enable");

	// Without a pending flag no calendar or DMA request is forwarded.
	chk_no_flag_no_req: assert property (
		@(posedge i_clk) disable iff (!i_nrst)
		!i_calendar_flag && !i_dma5_flag
		|=> !o_calendar_req && !o_dma5_req)
		else $error("Request raised without its pending flag");

	// Without a pending flag no CAN request is forwarded either.
	chk_can_needs_flag: assert property (
		@(posedge i_clk) disable iff (!i_nrst)
		!i_can_event_flag && !i_can_rx_flag
		|=> !o_can_event_req && !o_can_rx_req)
		else $error("CAN request raised without its pending flag");

endmodule

// [ieg_interrupt_enable_group_bits_tb_top.sv]
`timescale 1ns/100ps
`include "ieg_params.svh"
module ieg_interrupt_enable_group_bits_tb_top;
	import ieg_pkg::*;
	logic             clk    = 1'b0;
	logic             nrst   = 1'b0;
	logic             hsel   = 1'b0;
	logic      [31:0] haddr  = 32'h0;
	logic      [31:0] hwdata = 32'h0;
	ieg_trans_t       htrans = IEG_TR_IDLE;
	logic             hwrite = 1'b0;
	logic      [2:0]  hsize  = 3'h2;
	logic      [3:0]  flg    = 4'h0;
	wire logic [31:0] hrdata;
	wire logic        hready;
	wire logic        hresp;
	wire logic [3:0]  req;
	wire logic [3:0]  req_nc;
	int               error_cnt = 0;
	int               cmp_count = 0;
	int               seed      = 56592;
	logic      [31:0] rd;
	logic      [31:0] wd;
	logic      [3:0]  en;

	// Full part drives the bus; the part without CAN shadows it.
	ieg_interrupt_enable_group_bits DUT (.i_clk(clk), .i_nrst(nrst),
		.i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
		.i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata),
		.i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready),
		.o_hresp(hresp), .i_can_event_flag(flg[0]),
		.i_can_rx_flag(flg[1]), .i_calendar_flag(flg[2]),
		.i_dma5_flag(flg[3]), .o_can_event_req(req[0]),
		.o_can_rx_req(req[1]), .o_calendar_req(req[2]),
		.o_dma5_req(req[3]));
	ieg_interrupt_enable_group_bits #(.CAN_PRESENT(1'b0)) DUT_NC (
		.i_clk(clk), .i_nrst(nrst), .i_hsel(hsel), .i_haddr(haddr),
		.i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize),
		.i_hwdata(hwdata), .i_hready(hready), .o_hrdata(),
		.o_hreadyout(), .o_hresp(), .i_can_event_flag(flg[0]),
		.i_can_rx_flag(flg[1]), .i_calendar_flag(flg[2]),
		.i_dma5_flag(flg[3]), .o_can_event_req(req_nc[0]),
		.o_can_rx_req(req_nc[1]), .o_calendar_req(req_nc[2]),
		.o_dma5_req(req_nc[3]));

	// Free-running 20 MHz clock.
	always #25 clk = ~clk;

	// One comparison; four-state equality so an unknown never matches.
	task automatic chk(input string nm, input logic [31:0] e, g);
		cmp_count++;
		if (g !== e) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Single word transfer; waits on hready at both phase ends.
	task automatic xfer(input logic w, input logic [31:0] a, d,
		output logic [31:0] r);
		hsel   <= 1'b1;
		haddr  <= a;
		htrans <= IEG_TR_NONSEQ;
		hwrite <= w;
		do @(posedge clk); while (hready !== 1'b1);
		htrans <= IEG_TR_IDLE;
		hwdata <= d;
		do @(posedge clk); while (hready !== 1'b1);
		r = hrdata;
		chk("hresp", 32'h0, {31'h0, hresp});
	endtask

	// Expected requests: each flag passes only when its enable is set.
	function automatic logic [3:0] gate(input logic [3:0] f, e, input bit cp);
		gate = f & {e[3], e[2], e[1] & cp, e[0] & cp};
	endfunction

	// Prints the counts and the verdict, then stops the run.
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// Cuts a hang short well beyond the expected run of roughly 520 cycles.
	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		finish_test();
	end

	// Main sequence: reset values, masks, gating, second reset.
	initial begin
		repeat (16) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		xfer(0, `IEG_OFS_CAN_EN, 0, rd);
		chk("can_en reset", 32'h0, rd);
		xfer(0, `IEG_OFS_GROUP3, 0, rd);
		chk("group3 reset", 32'h0, rd);
		$display("test reset_values done");
		for (int i = 0; i < 12; i++) begin
			wd = (i == 0) ? 32'hffffffff : $random(seed);
			xfer(1, `IEG_OFS_GROUP3, wd, rd);
			xfer(0, `IEG_OFS_GROUP3, 0, rd);
			chk("group3", wd & {16'h0, `IEG_MASK_GROUP3}, rd);
			xfer(1, `IEG_OFS_CAN_EN, ~wd, rd);
			xfer(0, `IEG_OFS_CAN_EN, 0, rd);
			chk("can_en", ~wd & {16'h0, `IEG_MASK_CAN_EN}, rd);
			xfer(1, 32'h00c, wd, rd);
			xfer(0, 32'h00c, 0, rd);
			chk("unmapped", 32'h0, rd);
		end
		$display("test register_masks done");
		for (int i = 0; i < 16; i++) begin
			en = i[3:0];
			xfer(1, `IEG_OFS_CAN_EN, {28'h0, en[0], en[1], 2'b00}, rd);
			xfer(1, `IEG_OFS_GROUP3, {17'h0, en[2], en[3], 13'h0}, rd);
			xfer(0, `IEG_OFS_STATUS, 0, rd);
			chk("flags kept", {28'h0, flg}, {28'h0, rd[3:0]});
			for (int k = 0; k < 4; k++) begin
				flg <= (k == 0) ? 4'hf : 4'($random(seed));
				@(posedge clk);
				@(posedge clk);
				chk("req", gate(flg, en, 1), req);
				chk("req no can", gate(flg, en, 0), req_nc);
				xfer(0, `IEG_OFS_STATUS, 0, rd);
				chk("status", {24'h0, gate(flg, en, 1), flg}, rd);
			end
		end
		$display("test gating done");
		@(posedge clk);
		nrst <= 1'b0;
		@(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		xfer(0, `IEG_OFS_GROUP3, 0, rd);
		chk("group3 rereset", 32'h0, rd);
		chk("req rereset", 32'h0, {28'h0, req});
		$display("test second_reset done");
		finish_test();
	end
endmodule
